// [rtl/ofs_pkg.sv]
// package: register map, pin slots, timing counts and state types of the output fault supervisor
package ofs_pkg;

    localparam int          OFS_NOUT        = 8;
    localparam int          OFS_AW          = 8;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL_OFF    = 8'h00;
    localparam logic [7:0]  OFS_STATUS_OFF  = 8'h04;
    localparam logic [7:0]  OFS_IRQ_ST_OFF  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_CLR_OFF = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_EN_OFF  = 8'h10;

    // control register fields
    localparam int          OFS_CTRL_CMD_LSB   = 0;
    localparam int          OFS_CTRL_SINK_LSB  = 8;
    localparam int          OFS_CTRL_SLEEP_BIT = 16;
    localparam logic [7:0]  OFS_CMD_RST        = 8'h00;
    localparam logic [7:0]  OFS_SINK_RST       = 8'hFF;

    // status register fields
    localparam int          OFS_ST_OL_LSB   = 0;
    localparam int          OFS_ST_OV_BIT   = 8;
    localparam int          OFS_ST_TRIM_BIT = 9;
    localparam int          OFS_ST_UV_BIT   = 10;
    localparam int          OFS_ST_LOW_BIT  = 11;

    // interrupt bits
    localparam int          OFS_IRQ_W      = 3;
    localparam int          OFS_IRQ_OL_BIT = 0;
    localparam int          OFS_IRQ_OV_BIT = 1;
    localparam int          OFS_IRQ_UV_BIT = 2;

    // slots of the pin synchroniser
    localparam int          OFS_PIN_CS   = 8;
    localparam int          OFS_PIN_UVL  = 9;
    localparam int          OFS_PIN_UVB  = 10;
    localparam int          OFS_PIN_OV   = 11;
    localparam int          OFS_PIN_LOW  = 12;
    localparam int          OFS_PIN_TRIM = 13;
    localparam int          OFS_PIN_W    = 14;
    // select idles high, so its slot resets high; every other slot resets low
    localparam logic [13:0] OFS_PIN_RST  = 14'h0100;

    // open-load filter: window 100 us to 450 us, the least time is used
    localparam int unsigned OFS_CLK_NS     = 50;
    localparam int unsigned OFS_FLT_MIN_NS = 100000;
    localparam int unsigned OFS_FLT_MAX_NS = 450000;
    localparam int unsigned OFS_FLT_CYC    = (OFS_FLT_MIN_NS + OFS_CLK_NS - 1) / OFS_CLK_NS;
    localparam int          OFS_TMR_W      = 12;
    localparam logic [11:0] OFS_TMR_LOAD   = 12'(OFS_FLT_CYC - 1);

    typedef enum logic [1:0] {
        OFS_TS_WAIT  = 2'b00,
        OFS_TS_ARMED = 2'b01
    } ofs_tmr_st_t;

    typedef struct packed {
        logic [7:0]           cmd;
        logic [7:0]           sink;
        logic                 sleep;
        logic [7:0]           ol_lat;
        logic [OFS_IRQ_W-1:0] irq_stat;
        logic [OFS_IRQ_W-1:0] irq_en;
        logic [OFS_TMR_W-1:0] tmr;
        ofs_tmr_st_t          st;
        logic                 cs_d;
        logic                 ov_d;
        logic                 uv_d;
        logic [31:0]          rdata;
    } ofs_state_t;

endpackage

// [rtl/ofs_sync_if.sv]
// interface: raw pin levels in, synchronised levels out
`timescale 1ns/1ps
`default_nettype none
interface ofs_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] stable;

    modport sync (input raw, output stable);
    modport user (output raw, input stable);
endinterface
`default_nettype wire

// [rtl/ofs_pin_sync.sv]
// module: three-stage pin synchroniser, a level counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ofs_pin_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    ofs_sync_if.sync  pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } ofs_sync_st_t;

    ofs_sync_st_t s_reg;
    ofs_sync_st_t s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pins.raw;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (s_reg.s2[i] == s_reg.s3[i]) begin
                s_next.lvl[i] = s_reg.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // each stage resets to the pin's idle level, so release of reset makes no false edge
            s_reg <= {RST, RST, RST, RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins.stable = s_reg.lvl;
endmodule
`default_nettype wire

// [rtl/ofs_top.sv]
// module: output fault supervisor with open-load filter, supply shutdown and apb registers
// What this block does
// - open load is checked only on outputs whose command bit is low
// - each output has its own comparator and its own fault flag
// - pull-down sinks are on from power-up; detection needs the sink on
// - an output with its sink off reports open load as 0
// - sinks go off only in sleep or by a software write
// - comparators are filtered by a delay of 100 to 450 us
// - each chip-select rising edge restarts the delay; comparators ignored till expiry
// - a fault stays latched after its cause leaves, until the host reads it
// - logic or battery under-voltage forces outputs off and resets control
// - low battery keeps the commanded outputs; its status is flagged only
// - battery over-voltage holds all outputs off until the supply recovers
// - trim flag is reported: 0 untrimmed, 1 trimmed
// - battery over-voltage flag is reported: 1 present, 0 fine
`timescale 1ns/1ps
`default_nettype none
module ofs_top
    import ofs_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [7:0]    paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [7:0]    ol_cmp_pin,
    input  wire logic          cs_pin,
    input  wire logic          uv_logic_pin,
    input  wire logic          uv_battery_supply_pin,
    input  wire logic          ov_battery_supply_pin,
    input  wire logic          low_battery_supply_pin,
    input  wire logic          osc_trimmed_pin,
    output logic      [7:0]    out_en,
    output logic      [7:0]    sink_en,
    output logic               irq
);

    function automatic logic ofs_hit(input logic [7:0] a);
        ofs_hit = (a == OFS_CTRL_OFF) || (a == OFS_STATUS_OFF) || (a == OFS_IRQ_ST_OFF)
               || (a == OFS_IRQ_CLR_OFF) || (a == OFS_IRQ_EN_OFF);
    endfunction

    ofs_sync_if #(.W(OFS_PIN_W)) pins_if ();

    ofs_state_t         s_reg;
    ofs_state_t         s_next;
    logic [7:0]         cmp;
    logic               cs_s;
    logic               uv_s;
    logic               ov_s;
    logic               low_s;
    logic               trim_s;
    logic               acc;
    logic               setup;
    logic               wr;
    logic               rd_status;
    logic               cs_rise;
    logic               armed;
    logic [7:0]         sink_eff;
    logic [7:0]         fault_now;
    logic [7:0]         ol_stat;
    logic [OFS_IRQ_W-1:0] ev;

    assign pins_if.raw = {osc_trimmed_pin, low_battery_supply_pin, ov_battery_supply_pin,
                          uv_battery_supply_pin, uv_logic_pin, cs_pin, ol_cmp_pin};

    // select resets to its idle high level, so release of reset is not taken for a frame end
    ofs_pin_sync #(
        .W   (OFS_PIN_W),
        .RST (OFS_PIN_RST)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins_if)
    );

    assign cmp    = pins_if.stable[7:0];
    assign cs_s   = pins_if.stable[OFS_PIN_CS];
    assign uv_s   = pins_if.stable[OFS_PIN_UVL] | pins_if.stable[OFS_PIN_UVB];
    assign ov_s   = pins_if.stable[OFS_PIN_OV];
    assign low_s  = pins_if.stable[OFS_PIN_LOW];
    assign trim_s = pins_if.stable[OFS_PIN_TRIM];

    assign acc       = psel & penable;
    assign setup     = psel & ~penable;
    assign wr        = acc & pwrite;
    assign rd_status = acc & ~pwrite & (paddr == OFS_STATUS_OFF);
    assign cs_rise   = cs_s & ~s_reg.cs_d;
    assign armed     = (s_reg.st == OFS_TS_ARMED);

    // sleep gates every sink without touching the stored enables
    assign sink_eff = s_reg.sink & ~{8{s_reg.sleep}};

    // bitwise, so each output's comparator stands alone
    assign fault_now = cmp & ~s_reg.cmd & sink_eff & {8{armed}};

    assign ol_stat = s_reg.ol_lat & sink_eff;

    always_comb begin
        s_next      = s_reg;
        s_next.cs_d = cs_s;
        s_next.ov_d = ov_s;
        s_next.uv_d = uv_s;
        ev          = '0;

        // filter timer, restarted by every chip-select rise
        case (s_reg.st)
            OFS_TS_WAIT: begin
                if (cs_rise) begin
                    s_next.tmr = OFS_TMR_LOAD;
                end else if (s_reg.tmr == '0) begin
                    s_next.st = OFS_TS_ARMED;
                end else begin
                    s_next.tmr = s_reg.tmr - 12'h001;
                end
            end
            OFS_TS_ARMED: begin
                if (cs_rise) begin
                    s_next.st  = OFS_TS_WAIT;
                    s_next.tmr = OFS_TMR_LOAD;
                end
            end
            default: begin
                s_next.st  = OFS_TS_WAIT;
                s_next.tmr = OFS_TMR_LOAD;
            end
        endcase

        // a fault present at the read stays latched, so a set wins over the clear
        if (rd_status) begin
            s_next.ol_lat = fault_now;
        end else begin
            s_next.ol_lat = s_reg.ol_lat | fault_now;
        end

        ev[OFS_IRQ_OL_BIT] = |(fault_now & ~s_reg.ol_lat);
        ev[OFS_IRQ_OV_BIT] = ov_s & ~s_reg.ov_d;
        ev[OFS_IRQ_UV_BIT] = uv_s & ~s_reg.uv_d;

        if (wr) begin
            case (paddr)
                OFS_CTRL_OFF: begin
                    s_next.cmd   = pwdata[OFS_CTRL_CMD_LSB +: 8];
                    s_next.sink  = pwdata[OFS_CTRL_SINK_LSB +: 8];
                    s_next.sleep = pwdata[OFS_CTRL_SLEEP_BIT];
                end
                OFS_IRQ_CLR_OFF: begin
                    s_next.irq_stat = s_reg.irq_stat & ~pwdata[OFS_IRQ_W-1:0];
                end
                OFS_IRQ_EN_OFF: begin
                    s_next.irq_en = pwdata[OFS_IRQ_W-1:0];
                end
                default: begin
                    s_next.irq_en = s_reg.irq_en;
                end
            endcase
        end
        s_next.irq_stat = s_next.irq_stat | ev;

        // under-voltage takes precedence over a control register write in the same cycle
        if (uv_s) begin
            s_next.cmd   = OFS_CMD_RST;
            s_next.sink  = OFS_SINK_RST;
            s_next.sleep = 1'b0;
        end

        // read data is captured in the setup cycle so prdata comes from a flop
        if (setup) begin
            case (paddr)
                OFS_CTRL_OFF:   s_next.rdata = {15'h0000, s_reg.sleep, s_reg.sink, s_reg.cmd};
                OFS_STATUS_OFF: s_next.rdata = {20'h00000, low_s, uv_s, trim_s, ov_s, ol_stat};
                OFS_IRQ_ST_OFF: s_next.rdata = {29'h00000000, s_reg.irq_stat};
                OFS_IRQ_EN_OFF: s_next.rdata = {29'h00000000, s_reg.irq_en};
                default:        s_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg          <= '0;
            s_reg.cmd      <= OFS_CMD_RST;
            s_reg.sink     <= OFS_SINK_RST;
            s_reg.st       <= OFS_TS_WAIT;
            s_reg.tmr      <= OFS_TMR_LOAD;
            s_reg.cs_d     <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // low battery is deliberately not a gate: the command still drives the outputs
    assign out_en  = s_reg.cmd & ~{8{ov_s | uv_s}};
    assign sink_en = sink_eff;
    assign prdata  = s_reg.rdata;
    assign pready  = 1'b1;
    assign pslverr = acc & ~ofs_hit(paddr);
    assign irq     = |(s_reg.irq_stat & s_reg.irq_en);

    // ---- assertions ----

    a_ol_cmd_off: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.ol_lat & ~$past(s_reg.ol_lat) & $past(s_reg.cmd)) == 8'h00)
        else $error("open load latched on an output commanded on");

    a_ol_per_out: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_status |=> ((s_reg.ol_lat ^ $past(s_reg.ol_lat)) & ~$past(fault_now)) == 8'h00)
        else $error("open load flag changed without its own comparator");

    a_sink_pwrup: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> s_reg.sink == OFS_SINK_RST)
        else $error("sinks not enabled after reset");

    a_sink_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (ol_stat & ~sink_en) == 8'h00)
        else $error("open load reported with sink off");

    a_sink_off_cause: assert property (@(posedge pclk) disable iff (!presetn)
        (|($past(sink_en) & ~sink_en)) |-> ($past(wr) && $past(paddr) == OFS_CTRL_OFF))
        else $error("sink turned off without a write");

    a_tmr_restart: assert property (@(posedge pclk) disable iff (!presetn)
        cs_rise |=> (s_reg.st == OFS_TS_WAIT) && (s_reg.tmr == OFS_TMR_LOAD))
        else $error("filter timer not restarted by chip select");

    a_tmr_blind: assert property (@(posedge pclk) disable iff (!presetn)
        cs_rise ##1 (!cs_rise)[*8] |-> fault_now == 8'h00)
        else $error("comparator seen before filter delay");

    a_ol_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_status |=> (s_reg.ol_lat & $past(s_reg.ol_lat)) == $past(s_reg.ol_lat))
        else $error("latched open load lost without a read");

    a_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_status |=> s_reg.ol_lat == $past(fault_now))
        else $error("read did not clear stale open load flags");

    a_uv_reset: assert property (@(posedge pclk) disable iff (!presetn)
        uv_s |-> out_en == 8'h00 ##1 (s_reg.cmd == OFS_CMD_RST && s_reg.sink == OFS_SINK_RST))
        else $error("under-voltage did not reset control");

    a_low_run: assert property (@(posedge pclk) disable iff (!presetn)
        (low_s && !ov_s && !uv_s) |-> out_en == s_reg.cmd)
        else $error("low battery altered commanded outputs");

    a_ov_off: assert property (@(posedge pclk) disable iff (!presetn)
        ov_s |-> out_en == 8'h00)
        else $error("outputs on during over-voltage");

    a_trim_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == OFS_STATUS_OFF) |=> prdata[OFS_ST_TRIM_BIT] == $past(trim_s))
        else $error("trim flag misreported");

    a_ov_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == OFS_STATUS_OFF) |=> prdata[OFS_ST_OV_BIT] == $past(ov_s))
        else $error("over-voltage flag misreported");

    a_fault_cmd_on: assert property (@(posedge pclk) disable iff (!presetn)
        (fault_now & s_reg.cmd) == 8'h00)
        else $error("comparator seen on an output commanded on");

    a_ol_sink_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.ol_lat & ~$past(s_reg.ol_lat) & ~$past(sink_en)) == 8'h00)
        else $error("open load latched with its sink off");

    a_sleep_sink: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.sleep |-> sink_en == 8'h00)
        else $error("sink left on in sleep");

    a_tmr_bound: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.st == OFS_TS_WAIT) |-> s_reg.tmr <= OFS_TMR_LOAD)
        else $error("filter timer beyond its load value");

    a_armed_only: assert property (@(posedge pclk) disable iff (!presetn)
        !armed |-> fault_now == 8'h00)
        else $error("comparator used before timer expiry");

    a_ol_report: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == OFS_STATUS_OFF) |=> prdata[7:0] == $past(ol_stat))
        else $error("latched open load not reported");

    a_uv_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        uv_s |=> (!s_reg.sleep && s_reg.cmd == OFS_CMD_RST))
        else $error("under-voltage left sleep or command set");

    a_uv_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == OFS_STATUS_OFF) |=> prdata[OFS_ST_UV_BIT] == $past(uv_s))
        else $error("under-voltage flag misreported");

    a_low_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == OFS_STATUS_OFF) |=> prdata[OFS_ST_LOW_BIT] == $past(low_s))
        else $error("low battery flag misreported");

    a_cmd_kept_ov: assert property (@(posedge pclk) disable iff (!presetn)
        (ov_s && !uv_s && !wr) |=> s_reg.cmd == $past(s_reg.cmd))
        else $error("command lost during over-voltage");

    a_ov_recover: assert property (@(posedge pclk) disable iff (!presetn)
        (!ov_s && !uv_s) |-> out_en == s_reg.cmd)
        else $error("outputs not restored after supply recovery");

endmodule
`default_nettype wire

// [dv/ofs_pin_model.sv]
// partner model: host-side pins, chip select frames, comparator and supply levels
`timescale 1ns/1ps
`default_nettype none
module ofs_pin_model (
    input  wire logic       pclk,
    input  wire logic       cs_req,
    input  wire logic [7:0] cmp_req,
    input  wire logic [4:0] sup_req,
    output logic            cs_pin,
    output logic [7:0]      ol_cmp_pin,
    output logic            uv_logic_pin,
    output logic            uv_battery_supply_pin,
    output logic            ov_battery_supply_pin,
    output logic            low_battery_supply_pin,
    output logic            osc_trimmed_pin
);
    // host select and analog levels reach the pins one clock after they are requested
    // select idles high; the filter restart comes from the rising end of a frame
    // supply order in every 5-bit word: uv logic, uv battery, ov, low battery, trimmed
    always @(posedge pclk) begin
        cs_pin     <= cs_req;
        ol_cmp_pin <= cmp_req;
        {uv_logic_pin, uv_battery_supply_pin, ov_battery_supply_pin, low_battery_supply_pin,
         osc_trimmed_pin} <= sup_req;
    end
endmodule
`default_nettype wire

// [dv/test_output_fault_supply_protection.sv]
// testbench: open-load filter, latching, supply shutdown and apb access of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module test_output_fault_supply_protection;
    import ofs_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  cmp;
    logic        cs, uvl, uvb, ov, low, trim;
    logic        cs_req = 1'b1;
    logic [7:0]  cmp_req = 8'h00;
    logic [4:0]  sup_req = 5'h01;
    logic [7:0]  out_en;
    logic [7:0]  sink_en;
    logic        irq;
    logic [31:0] r;
    logic        e;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc = 0;

    ofs_top ofs_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ol_cmp_pin(cmp), .cs_pin(cs), .uv_logic_pin(uvl), .uv_battery_supply_pin(uvb),
        .ov_battery_supply_pin(ov), .low_battery_supply_pin(low), .osc_trimmed_pin(trim),
        .out_en(out_en), .sink_en(sink_en), .irq(irq));
    ofs_pin_model ofs_pin_model_inst (.pclk(pclk), .cs_req(cs_req), .cmp_req(cmp_req), .sup_req(sup_req),
        .cs_pin(cs), .ol_cmp_pin(cmp), .uv_logic_pin(uvl),
        .uv_battery_supply_pin(uvb), .ov_battery_supply_pin(ov), .low_battery_supply_pin(low),
        .osc_trimmed_pin(trim));

    always #25 pclk = ~pclk;

    // the whole run needs about 2240 cycles; a hang stops well before the global limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %08X expected %08X", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // the request stands until pready is seen high at a rising edge; data is taken at that edge
    task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        apb_xfer(a, 1'b0, 32'h0);
    endtask

    // host select frame: low for len clocks, then back to its idle high level
    task automatic cs_frame(input int len);
        @(posedge pclk);
        cs_req <= 1'b0;
        repeat (len) @(posedge pclk);
        cs_req <= 1'b1;
    endtask

    task automatic set_cmp(input logic [7:0] v);
        @(posedge pclk);
        cmp_req <= v;
    endtask

    task automatic set_sup(input logic [4:0] v);
        @(posedge pclk);
        sup_req <= v;
    endtask

    task automatic t_reset();
        settle(0);
        chk(32'(sink_en), 32'h000000FF);
        chk(32'(out_en), 32'h00000000);
        rd(OFS_CTRL_OFF);
        chk(r, 32'h0000FF00);
        rd(OFS_IRQ_EN_OFF);
        chk(r, 32'h00000000);
        $display("test reset values done");
    endtask

    task automatic t_openload();
        apb_xfer(OFS_IRQ_EN_OFF, 1'b1, 32'h1);
        apb_xfer(OFS_CTRL_OFF, 1'b1, 32'h0000FF01);
        set_cmp(8'hFF);
        cs_frame(8);
        settle(1800);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hFF, 32'h0);
        settle(260);
        chk(32'(irq), 32'h1);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hFF, 32'hFE);
        apb_xfer(OFS_IRQ_EN_OFF, 1'b1, 32'h0);
        settle(1);
        chk(32'(irq), 32'h0);
        apb_xfer(OFS_IRQ_EN_OFF, 1'b1, 32'h1);
        settle(1);
        chk(32'(irq), 32'h1);
        set_cmp(8'h00);
        settle(6);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hFF, 32'hFE);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hFF, 32'h00);
        apb_xfer(OFS_IRQ_CLR_OFF, 1'b1, 32'h1);
        settle(1);
        chk(32'(irq), 32'h0);
        set_cmp(8'hFF);
        settle(6);
        rd(OFS_STATUS_OFF);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hFF, 32'hFE);
        apb_xfer(OFS_CTRL_OFF, 1'b1, 32'h0000FD01);
        settle(6);
        chk(32'(sink_en), 32'hFD);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hFF, 32'hFC);
        apb_xfer(OFS_CTRL_OFF, 1'b1, 32'h0001FD01);
        settle(1);
        chk(32'(sink_en), 32'h00);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hFF, 32'h00);
        set_cmp(8'h00);
        $display("test open load done");
    endtask

    task automatic t_supply();
        apb_xfer(OFS_CTRL_OFF, 1'b1, 32'h0000FFFF);
        set_sup(5'b00011);
        settle(6);
        chk(32'(out_en), 32'hFF);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hF00, 32'hA00);
        set_sup(5'b00101);
        settle(6);
        chk(32'(out_en), 32'h00);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hF00, 32'h300);
        set_sup(5'b00000);
        settle(6);
        chk(32'(out_en), 32'hFF);
        rd(OFS_STATUS_OFF);
        chk(r & 32'hF00, 32'h000);
        for (int i = 0; i < 2; i++) begin
            set_sup(i == 0 ? 5'b10001 : 5'b01001);
            settle(6);
            chk(32'(out_en), 32'h00);
            rd(OFS_CTRL_OFF);
            chk(r, 32'h0000FF00);
            set_sup(5'b00001);
            settle(6);
            chk(32'(out_en), 32'h00);
            apb_xfer(OFS_CTRL_OFF, 1'b1, 32'h0000FFFF);
        end
        // sticky events: open load from the last test, then over- and under-voltage rises here
        settle(0);
        chk(32'(irq), 32'h1);
        rd(OFS_IRQ_ST_OFF);
        chk(r, 32'h00000007);
        apb_xfer(OFS_IRQ_CLR_OFF, 1'b1, 32'h00000007);
        rd(OFS_IRQ_ST_OFF);
        chk(r, 32'h00000000);
        settle(0);
        chk(32'(irq), 32'h0);
        $display("test supply done");
    endtask

    task automatic t_apb_err();
        rd(8'h20);
        chk(r, 32'h0);
        chk(32'(e), 32'h1);
        rd(OFS_IRQ_CLR_OFF);
        chk(r, 32'h0);
        chk(32'(e), 32'h0);
        $display("test bus errors done");
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_openload();
        t_supply();
        t_apb_err();
        stop_test();
    end
endmodule
`default_nettype wire
